// File: bench/sbi_link_properties.sv
// Checker of timing and inversion properties on the hub to processor link
`timescale 1ns/1ps
`default_nettype none
module sbi_link_properties (
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic                       bus_clk,
  input wire logic                       h2d_strobe,
  input wire logic [sbi_pkg::KIND_W-1:0] h2d_kind,
  input wire sbi_pkg::sbi_phase_t        h2d_phase,
  input wire logic                       d2h_strobe,
  input wire logic [sbi_pkg::KIND_W-1:0] d2h_kind,
  input wire sbi_pkg::sbi_phase_t        d2h_phase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Flag low exactly where the recovered group has over 8 actives; few low wires
  function automatic logic grp_ok(input sbi_pkg::sbi_phase_t p);
    logic        ok;
    logic [15:0] d;
    ok = 1'b1;
    for (int g = 0; g < 4; g++) begin
      d  = p.flag_n[g] ? ~p.data_n[g*16 +: 16] : p.data_n[g*16 +: 16];
      ok = ok & ((!p.flag_n[g]) == ($countones(d) > 8));
      ok = ok & ($countones(~p.data_n[g*16 +: 16]) <= 9);
    end
    return ok;
  endfunction : grp_ok

  property p_h2d_groups;
    $changed(h2d_strobe) |-> grp_ok(h2d_phase);
  endproperty
  a_h2d_groups: assert property (p_h2d_groups) else $error("h2d group flags wrong");

  property p_d2h_groups;
    $changed(d2h_strobe) |-> grp_ok(d2h_phase);
  endproperty
  a_d2h_groups: assert property (p_d2h_groups) else $error("d2h group flags wrong");

  property p_bclk_high;
    $rose(bus_clk) |-> bus_clk [*8] ##1 !bus_clk;
  endproperty
  a_bclk_high: assert property (p_bclk_high) else $error("bus clock high time wrong");

  property p_bclk_low;
    $fell(bus_clk) |-> (!bus_clk) [*8] ##1 bus_clk;
  endproperty
  a_bclk_low: assert property (p_bclk_low) else $error("bus clock low time wrong");

  property p_h2d_space;
    $changed(h2d_strobe) |=> $stable(h2d_strobe) [*3];
  endproperty
  a_h2d_space: assert property (p_h2d_space) else $error("h2d phases too close");

  property p_d2h_space;
    $changed(d2h_strobe) |=> $stable(d2h_strobe) [*3];
  endproperty
  a_d2h_space: assert property (p_d2h_space) else $error("d2h phases too close");

  property p_h2d_hold;
    $changed(h2d_strobe) |=> ($stable(h2d_phase) && $stable(h2d_kind)) [*3];
  endproperty
  a_h2d_hold: assert property (p_h2d_hold) else $error("h2d phase not held");

  property p_d2h_hold;
    $changed(d2h_strobe) |=> ($stable(d2h_phase) && $stable(d2h_kind)) [*3];
  endproperty
  a_d2h_hold: assert property (p_d2h_hold) else $error("d2h phase not held");
endmodule : sbi_link_properties
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench joining the hub end and the processor end
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk;
  logic        reset;
  logic        tx_valid, tx_taken, rx_valid;
  logic [1:0]  tx_kind, rx_kind;
  logic [63:0] tx_data, rx_data, up_tx_data, up_rx_data;
  logic        ds_wr_valid, ds_wr_ready, ds_wr_retry, mem_wr_valid, eoi_valid;
  logic [31:0] ds_wr_addr, ds_wr_data, mem_wr_addr, mem_wr_data;
  logic [7:0]  eoi_vector;
  logic        up_tx_valid, up_tx_taken, up_rx_valid;
  int          failures, cmp_count, retries, cyc;
  logic [67:0] cq[$];
  logic [63:0] hq[$], mq[$];
  logic [7:0]  eq[$];
  logic [63:0] words [8];

  sbi_link_if u_link ();
  sbi_cpu_end u_sbi_cpu_end (.clk(clk), .reset(reset), .link(u_link), .tx_valid(tx_valid),
    .tx_kind(tx_kind), .tx_data(tx_data), .tx_taken(tx_taken), .rx_valid(rx_valid),
    .rx_kind(rx_kind), .rx_data(rx_data));
  sbi_hub_end #(.THREADS(4), .PRIO_W(8)) u_sbi_hub_end (.clk(clk), .reset(reset),
    .link(u_link), .ds_wr_valid(ds_wr_valid), .ds_wr_addr(ds_wr_addr),
    .ds_wr_data(ds_wr_data), .ds_wr_ready(ds_wr_ready), .ds_wr_retry(ds_wr_retry),
    .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .eoi_valid(eoi_valid), .eoi_vector(eoi_vector), .up_tx_valid(up_tx_valid),
    .up_tx_data(up_tx_data), .up_tx_taken(up_tx_taken), .up_rx_valid(up_rx_valid),
    .up_rx_data(up_rx_data));
  sbi_link_properties u_props (.clk(clk), .reset(reset), .bus_clk(u_link.bus_clk),
    .h2d_strobe(u_link.h2d_strobe), .h2d_kind(u_link.h2d_kind), .h2d_phase(u_link.h2d_phase),
    .d2h_strobe(u_link.d2h_strobe), .d2h_kind(u_link.d2h_kind), .d2h_phase(u_link.d2h_phase));

  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // Collect single-cycle pulses away from the launching edge
  always @(negedge clk) begin
    if (up_rx_valid === 1'b1) hq.push_back(up_rx_data);
    if (rx_valid === 1'b1) cq.push_back({2'h0, rx_kind, rx_data});
    if (mem_wr_valid === 1'b1) mq.push_back({mem_wr_addr, mem_wr_data});
    if (eoi_valid === 1'b1) eq.push_back(eoi_vector);
    if (ds_wr_retry === 1'b1) retries++;
  end

  function automatic logic [67:0] enc(input logic [63:0] d);
    logic [3:0]  f;
    logic [63:0] w;
    f = 4'hf;
    w = ~d;
    for (int g = 0; g < 4; g++) begin
      if ($countones(d[g*16 +: 16]) > 8) begin
        f[g] = 1'b0;
        w[g*16 +: 16] = d[g*16 +: 16];
      end
    end
    return {f, w};
  endfunction : enc

  task automatic chk(input logic [67:0] got, input logic [67:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic print_verdict;
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // Leaves valid high so that a following call goes back to back
  task automatic cpu_send(input logic [1:0] k, input logic [63:0] d);
    tx_valid = 1'b1;
    tx_kind = k;
    tx_data = d;
    repeat (40) begin
      tick();
      if (tx_taken === 1'b1) break;
    end
    chk(tx_taken, 1'b1);
    chk(u_link.h2d_phase, enc(d));
  endtask : cpu_send

  task automatic hub_send(input logic [63:0] d);
    up_tx_valid = 1'b1;
    up_tx_data = d;
    repeat (40) begin
      tick();
      if (up_tx_taken === 1'b1) break;
    end
    chk(up_tx_taken, 1'b1);
    chk(u_link.d2h_phase, enc(d));
  endtask : hub_send

  task automatic expect_up(input logic [63:0] d);
    repeat (40) if (hq.size() == 0) tick();
    chk(hq.size() != 0, 1'b1);
    if (hq.size() != 0) chk(hq.pop_front(), d);
  endtask : expect_up

  task automatic expect_cpu(input logic [1:0] k, input logic [63:0] d);
    repeat (60) if (cq.size() == 0) tick();
    chk(cq.size() != 0, 1'b1);
    if (cq.size() != 0) chk(cq.pop_front(), {2'h0, k, d});
  endtask : expect_cpu

  task automatic ds_write(input logic [31:0] a, input logic [31:0] d);
    repeat (40) if (ds_wr_ready !== 1'b1) tick();
    ds_wr_valid = 1'b1;
    ds_wr_addr = a;
    ds_wr_data = d;
    tick();
    ds_wr_valid = 1'b0;
  endtask : ds_write

  // A whole line upstream, eight phases held back to back
  task automatic t_line_up;
    int t0;
    for (int i = 0; i < 8; i++) begin
      cpu_send(sbi_pkg::KIND_DATA, words[i]);
      if (i == 0) t0 = cyc;
    end
    chk(cyc - t0, 28);
    tx_valid = 1'b0;
    for (int i = 0; i < 8; i++) expect_up(words[i]);
  endtask : t_line_up

  task automatic t_line_down;
    int t0;
    for (int i = 0; i < 8; i++) begin
      hub_send(words[i]);
      if (i == 0) t0 = cyc;
    end
    chk(cyc - t0, 28);
    up_tx_valid = 1'b0;
    for (int i = 0; i < 8; i++) expect_cpu(sbi_pkg::KIND_DATA, words[i]);
  endtask : t_line_down

  // Second write while the slot is full is retried, then a window write
  task automatic t_retry;
    repeat (40) if (ds_wr_ready !== 1'b1) tick();
    ds_wr_valid = 1'b1;
    ds_wr_addr = 32'h1000_0040;
    ds_wr_data = 32'h0bad_f00d;
    tick();
    ds_wr_addr = 32'h1000_0080;
    tick();
    ds_wr_valid = 1'b0;
    repeat (6) tick();
    chk(mq.size(), 1);
    if (mq.size() != 0) chk(mq.pop_front(), 64'h1000_0040_0bad_f00d);
    chk(retries > 0, 1'b1);
    ds_write(32'hfee0_3000, 32'h0000_0041);
    expect_cpu(sbi_pkg::KIND_INTR, 64'hfee0_3000_0000_0041);
    chk(mq.size(), 0);
  endtask : t_retry

  task automatic t_lowest;
    cpu_send(sbi_pkg::KIND_TPR, 64'h0005);
    cpu_send(sbi_pkg::KIND_TPR, 64'h0103);
    cpu_send(sbi_pkg::KIND_TPR, 64'h0207);
    cpu_send(sbi_pkg::KIND_TPR, 64'h0309);
    cpu_send(sbi_pkg::KIND_TPR, 64'h0400);
    tx_valid = 1'b0;
    repeat (10) tick();
    ds_write(32'hfee0_2000, 32'h0000_0131);
    expect_cpu(sbi_pkg::KIND_INTR, 64'hfee0_1000_0000_0131);
    cpu_send(sbi_pkg::KIND_TPR, 64'h0108);
    tx_valid = 1'b0;
    repeat (10) tick();
    cpu_send(sbi_pkg::KIND_INTR, 64'hfee0_3000_0000_0122);
    tx_valid = 1'b0;
    expect_cpu(sbi_pkg::KIND_INTR, 64'hfee0_0000_0000_0122);
  endtask : t_lowest

  task automatic t_eoi;
    cpu_send(sbi_pkg::KIND_EOI, 64'h005a);
    cpu_send(sbi_pkg::KIND_EOI, 64'h00a5);
    tx_valid = 1'b0;
    repeat (20) if (eq.size() < 2) tick();
    chk(eq.size(), 2);
    if (eq.size() == 2) chk({eq[0], eq[1]}, 16'h5aa5);
  endtask : t_eoi

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    cyc = 0;
    tx_valid = 1'b0;
    tx_kind = 2'h0;
    tx_data = 64'h0;
    ds_wr_valid = 1'b0;
    ds_wr_addr = 32'h0;
    ds_wr_data = 32'h0;
    up_tx_valid = 1'b0;
    up_tx_data = 64'h0;
    failures = 0;
    cmp_count = 0;
    retries = 0;
    words = '{64'h0, 64'hffff_ffff_ffff_ffff, 64'h00ff_00ff_00ff_00ff, 64'h01ff_01ff_01ff_01ff,
              64'hffff_0000_fe00_0001, 64'h1234_5678_9abc_def0, 64'h7fff_8001_fffe_0003,
              64'h0f0f_ff7f_0001_aaaa};
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (2) tick();
    t_line_up();
    t_line_down();
    t_retry();
    t_lowest();
    t_eoi();
    print_verdict();
  end

  initial begin
    #100000;
    failures++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire

// File: rtl/sbi_cpu_end.sv
// Processor end of the link: phase sender and receiver
`timescale 1ns/1ps
`default_nettype none
module sbi_cpu_end (
  input  wire logic                        clk,
  input  wire logic                        reset,
  sbi_link_if.host                         link,
  input  wire logic                        tx_valid,
  input  wire logic [sbi_pkg::KIND_W-1:0]  tx_kind,
  input  wire logic [sbi_pkg::DATA_W-1:0]  tx_data,
  output logic                             tx_taken,
  output logic                             rx_valid,
  output logic [sbi_pkg::KIND_W-1:0]       rx_kind,
  output logic [sbi_pkg::DATA_W-1:0]       rx_data
);
  localparam int CNT_W = $clog2(sbi_pkg::BCLK_CYC) + 1;

  logic                        c1_q, c2_q, c3_q, lvl_q;
  logic                        rise;
  logic [CNT_W-1:0]            cnt_q;
  logic                        slot;
  logic                        s1_q, s2_q, s3_q, seen_q;
  logic [sbi_pkg::KIND_W-1:0]  k1_q, k2_q, k3_q;
  sbi_pkg::sbi_phase_t         p1_q, p2_q, p3_q;
  logic                        rx_new;
  logic                        strobe_q;
  logic [sbi_pkg::KIND_W-1:0]  kind_q;
  sbi_pkg::sbi_phase_t         phase_q;

  // Bus clock sampled and its rising edge found
  always_ff @(posedge clk) begin
    if (reset) begin
      c1_q  <= 1'b0;
      c2_q  <= 1'b0;
      c3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      c1_q <= link.bus_clk;
      c2_q <= c1_q;
      c3_q <= c2_q;
      if (c2_q == c3_q) begin
        lvl_q <= c3_q;
      end
    end
  end
  assign rise = (c2_q == c3_q) && c3_q && !lvl_q;

  // Four phase slots after each bus clock rising edge; none if the clock stops
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= CNT_W'(sbi_pkg::BCLK_CYC);
    end else if (rise) begin
      cnt_q <= CNT_W'(1);
    end else if (cnt_q < CNT_W'(sbi_pkg::BCLK_CYC)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign slot = rise || ((32'(cnt_q) % sbi_pkg::PHASE_CYC) == 0 &&
                         cnt_q < CNT_W'(sbi_pkg::BCLK_CYC));

  // Sender: one encoded phase per slot
  always_ff @(posedge clk) begin
    if (reset) begin
      strobe_q <= 1'b0;
      kind_q   <= sbi_pkg::KIND_DATA;
      phase_q  <= '1;
      tx_taken <= 1'b0;
    end else begin
      tx_taken <= slot && tx_valid;
      if (slot && tx_valid) begin
        strobe_q <= !strobe_q;
        kind_q   <= tx_kind;
        phase_q  <= sbi_pkg::sbi_encode(tx_data);
      end
    end
  end
  assign link.h2d_strobe = strobe_q;
  assign link.h2d_kind   = kind_q;
  assign link.h2d_phase  = phase_q;

  // Receiver synchronisers
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      k1_q <= sbi_pkg::KIND_DATA;
      k2_q <= sbi_pkg::KIND_DATA;
      k3_q <= sbi_pkg::KIND_DATA;
      p1_q <= '1;
      p2_q <= '1;
      p3_q <= '1;
    end else begin
      s1_q <= link.d2h_strobe;
      s2_q <= s1_q;
      s3_q <= s2_q;
      k1_q <= link.d2h_kind;
      k2_q <= k1_q;
      k3_q <= k2_q;
      p1_q <= link.d2h_phase;
      p2_q <= p1_q;
      p3_q <= p2_q;
    end
  end
  assign rx_new = (s2_q == s3_q) && (s3_q != seen_q);

  always_ff @(posedge clk) begin
    if (reset) begin
      seen_q   <= 1'b0;
      rx_valid <= 1'b0;
      rx_kind  <= sbi_pkg::KIND_DATA;
      rx_data  <= '0;
    end else begin
      rx_valid <= rx_new;
      if (rx_new) begin
        seen_q  <= s3_q;
        rx_kind <= k3_q;
        rx_data <= sbi_pkg::sbi_decode(p3_q);
      end
    end
  end
endmodule : sbi_cpu_end
`default_nettype wire

// File: rtl/sbi_hub_end.sv
// Hub end of the link: bus clock, inversion, interrupt forwarding
`timescale 1ns/1ps
`default_nettype none
module sbi_hub_end #(
  parameter int THREADS = 4,
  parameter int PRIO_W  = 8
) (
  input  wire logic                        clk,
  input  wire logic                        reset,
  sbi_link_if.dev                          link,
  input  wire logic                        ds_wr_valid,
  input  wire logic [sbi_pkg::ADDR_W-1:0]  ds_wr_addr,
  input  wire logic [sbi_pkg::ADDR_W-1:0]  ds_wr_data,
  output logic                             ds_wr_ready,
  output logic                             ds_wr_retry,
  output logic                             mem_wr_valid,
  output logic [sbi_pkg::ADDR_W-1:0]       mem_wr_addr,
  output logic [sbi_pkg::ADDR_W-1:0]       mem_wr_data,
  output logic                             eoi_valid,
  output logic [sbi_pkg::EOI_VEC_W-1:0]    eoi_vector,
  input  wire logic                        up_tx_valid,
  input  wire logic [sbi_pkg::DATA_W-1:0]  up_tx_data,
  output logic                             up_tx_taken,
  output logic                             up_rx_valid,
  output logic [sbi_pkg::DATA_W-1:0]       up_rx_data
);
  localparam int CYC_W = $clog2(sbi_pkg::BCLK_CYC);
  localparam int THR_W = $clog2(THREADS);
  localparam int AW    = sbi_pkg::ADDR_W;

  logic [CYC_W-1:0]            cyc_q;
  logic                        bus_clk_q;
  logic                        slot;
  logic                        s1_q, s2_q, s3_q, seen_q;
  logic [sbi_pkg::KIND_W-1:0]  k1_q, k2_q, k3_q;
  sbi_pkg::sbi_phase_t         p1_q, p2_q, p3_q;
  logic                        rx_new;
  logic [sbi_pkg::DATA_W-1:0]  rx_word;
  logic [PRIO_W-1:0]           prio_q [THREADS];
  logic [sbi_pkg::TPR_THR_W-1:0] tpr_thr;
  logic                        ipi_valid_q;
  logic [sbi_pkg::DATA_W-1:0]  ipi_msg_q;
  logic                        post_valid_q;
  logic                        post_valid_d;
  logic [AW-1:0]               post_addr_q;
  logic [AW-1:0]               post_data_q;
  logic                        post_is_intr;
  logic                        accept;
  logic                        take_post_intr;
  logic                        take_post_mem;
  logic                        take_ipi;
  logic [AW-1:0]               src_addr;
  logic [AW-1:0]               src_data;
  logic [AW-1:0]               red_addr;
  logic [THR_W-1:0]            low_idx;
  logic                        msg_valid_q;
  logic [sbi_pkg::DATA_W-1:0]  msg_q;
  logic                        send_msg;
  logic                        send_data;
  logic                        strobe_q;
  logic [sbi_pkg::KIND_W-1:0]  kind_q;
  sbi_pkg::sbi_phase_t         phase_q;

  // Bus clock divider; four phase slots per bus clock
  always_ff @(posedge clk) begin
    if (reset) begin
      cyc_q     <= '0;
      bus_clk_q <= 1'b0;
    end else begin
      cyc_q     <= (cyc_q == CYC_W'(sbi_pkg::BCLK_CYC - 1)) ? '0 : cyc_q + 1'b1;
      bus_clk_q <= (cyc_q < CYC_W'(sbi_pkg::BCLK_CYC / 2));
    end
  end
  assign slot         = (32'(cyc_q) % sbi_pkg::PHASE_CYC) == 0;
  assign link.bus_clk = bus_clk_q;

  // Receiver synchronisers
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      k1_q <= sbi_pkg::KIND_DATA;
      k2_q <= sbi_pkg::KIND_DATA;
      k3_q <= sbi_pkg::KIND_DATA;
      p1_q <= '1;
      p2_q <= '1;
      p3_q <= '1;
    end else begin
      s1_q <= link.h2d_strobe;
      s2_q <= s1_q;
      s3_q <= s2_q;
      k1_q <= link.h2d_kind;
      k2_q <= k1_q;
      k3_q <= k2_q;
      p1_q <= link.h2d_phase;
      p2_q <= p1_q;
      p3_q <= p2_q;
    end
  end
  assign rx_new  = (s2_q == s3_q) && (s3_q != seen_q);
  assign rx_word = sbi_pkg::sbi_decode(p3_q);
  assign tpr_thr = rx_word[sbi_pkg::TPR_THR_LSB +: sbi_pkg::TPR_THR_W];

  // Received data words and end of interrupt broadcast
  always_ff @(posedge clk) begin
    if (reset) begin
      seen_q      <= 1'b0;
      up_rx_valid <= 1'b0;
      up_rx_data  <= '0;
      eoi_valid   <= 1'b0;
      eoi_vector  <= '0;
    end else begin
      up_rx_valid <= rx_new && k3_q == sbi_pkg::KIND_DATA;
      eoi_valid   <= rx_new && k3_q == sbi_pkg::KIND_EOI;
      if (rx_new) begin
        seen_q <= s3_q;
      end
      if (rx_new && k3_q == sbi_pkg::KIND_DATA) begin
        up_rx_data <= rx_word;
      end
      if (rx_new && k3_q == sbi_pkg::KIND_EOI) begin
        eoi_vector <= rx_word[sbi_pkg::EOI_VEC_LSB +: sbi_pkg::EOI_VEC_W];
      end
    end
  end

  // Task priority table per thread
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int t = 0; t < THREADS; t++) begin
        prio_q[t] <= '0;
      end
    end else if (rx_new && k3_q == sbi_pkg::KIND_TPR && 32'(tpr_thr) < THREADS) begin
      prio_q[THR_W'(tpr_thr)] <= rx_word[sbi_pkg::TPR_PRIO_LSB +: PRIO_W];
    end
  end

  // Inter-processor interrupt waiting for the message stage
  always_ff @(posedge clk) begin
    if (reset) begin
      ipi_valid_q <= 1'b0;
      ipi_msg_q   <= '0;
    end else if (rx_new && k3_q == sbi_pkg::KIND_INTR) begin
      ipi_valid_q <= 1'b1;
      ipi_msg_q   <= rx_word;
    end else if (take_ipi) begin
      ipi_valid_q <= 1'b0;
    end
  end

  // Posted inbound write slot; a full slot retries the writer
  assign post_is_intr = post_addr_q[sbi_pkg::WIN_LSB +: sbi_pkg::WIN_W] == sbi_pkg::WIN_BASE;
  assign accept         = ds_wr_valid && ds_wr_ready;
  assign take_post_intr = post_valid_q && post_is_intr && !msg_valid_q;
  assign take_post_mem  = post_valid_q && !post_is_intr;
  assign take_ipi       = ipi_valid_q && !msg_valid_q && !(post_valid_q && post_is_intr);

  always_comb begin
    post_valid_d = post_valid_q;
    if (take_post_intr || take_post_mem) begin
      post_valid_d = 1'b0;
    end
    if (accept) begin
      post_valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      post_valid_q <= 1'b0;
      post_addr_q  <= '0;
      post_data_q  <= '0;
      ds_wr_ready  <= 1'b0;
      ds_wr_retry  <= 1'b0;
    end else begin
      post_valid_q <= post_valid_d;
      ds_wr_ready  <= !post_valid_d;
      ds_wr_retry  <= ds_wr_valid && !ds_wr_ready;
      if (accept) begin
        post_addr_q <= ds_wr_addr;
        post_data_q <= ds_wr_data;
      end
    end
  end

  // Ordinary posted writes leave toward memory
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_wr_valid <= 1'b0;
      mem_wr_addr  <= '0;
      mem_wr_data  <= '0;
    end else begin
      mem_wr_valid <= take_post_mem;
      if (take_post_mem) begin
        mem_wr_addr <= post_addr_q;
        mem_wr_data <= post_data_q;
      end
    end
  end

  // Lowest priority thread and destination redirection
  always_comb begin
    low_idx = '0;
    for (int t = 1; t < THREADS; t++) begin
      if (prio_q[t] < prio_q[low_idx]) begin
        low_idx = THR_W'(t);
      end
    end
    src_addr = take_post_intr ? post_addr_q : ipi_msg_q[sbi_pkg::MSG_ADDR_LSB +: AW];
    src_data = take_post_intr ? post_data_q : ipi_msg_q[AW-1:0];
    red_addr = src_addr;
    if (src_data[sbi_pkg::DM_LSB +: sbi_pkg::DM_W] == sbi_pkg::DM_LOWEST) begin
      red_addr[sbi_pkg::DEST_LSB +: sbi_pkg::DEST_W] = sbi_pkg::DEST_W'(low_idx);
    end
  end

  // Interrupt message stage
  assign send_msg  = slot && msg_valid_q;
  assign send_data = slot && !msg_valid_q && up_tx_valid;

  always_ff @(posedge clk) begin
    if (reset) begin
      msg_valid_q <= 1'b0;
      msg_q       <= '0;
    end else if (take_post_intr || take_ipi) begin
      msg_valid_q <= 1'b1;
      msg_q       <= {red_addr, src_data};
    end else if (send_msg) begin
      msg_valid_q <= 1'b0;
    end
  end

  // Sender: interrupt messages ahead of data words
  always_ff @(posedge clk) begin
    if (reset) begin
      strobe_q    <= 1'b0;
      kind_q      <= sbi_pkg::KIND_DATA;
      phase_q     <= '1;
      up_tx_taken <= 1'b0;
    end else begin
      up_tx_taken <= send_data;
      if (send_msg) begin
        strobe_q <= !strobe_q;
        kind_q   <= sbi_pkg::KIND_INTR;
        phase_q  <= sbi_pkg::sbi_encode(msg_q);
      end else if (send_data) begin
        strobe_q <= !strobe_q;
        kind_q   <= sbi_pkg::KIND_DATA;
        phase_q  <= sbi_pkg::sbi_encode(up_tx_data);
      end
    end
  end
  assign link.d2h_strobe = strobe_q;
  assign link.d2h_kind   = kind_q;
  assign link.d2h_phase  = phase_q;
endmodule : sbi_hub_end
`default_nettype wire

// File: rtl/sbi_link_if.sv
// System bus link between the hub end and the processor end
`timescale 1ns/1ps
`default_nettype none
interface sbi_link_if;
  logic                             bus_clk;
  logic                             h2d_strobe;
  logic [sbi_pkg::KIND_W-1:0]       h2d_kind;
  sbi_pkg::sbi_phase_t              h2d_phase;
  logic                             d2h_strobe;
  logic [sbi_pkg::KIND_W-1:0]       d2h_kind;
  sbi_pkg::sbi_phase_t              d2h_phase;

  modport dev (
    output bus_clk,
    output d2h_strobe,
    output d2h_kind,
    output d2h_phase,
    input  h2d_strobe,
    input  h2d_kind,
    input  h2d_phase
  );

  modport host (
    input  bus_clk,
    input  d2h_strobe,
    input  d2h_kind,
    input  d2h_phase,
    output h2d_strobe,
    output h2d_kind,
    output h2d_phase
  );
endinterface : sbi_link_if
`default_nettype wire

// File: rtl/sbi_pkg.sv
// Shared constants, phase type and group inversion functions of the link
// Overview of operation
// - Group of 16 with over 8 actives inverts
// - Flag n covers data bits 16n+15 to 16n
// - Receiver re-inverts groups whose flag is set
// - Every data phase carries its own flags
// - Active means 1 inside, low on wires
// - Never more than 9 actives per group
// - Writes to interrupt window become interrupt messages
// - Interrupt writes posted if room, else retried
// - Message issued only after the write posts
// - Lowest priority goes to least busy thread
// - Threads report task priority; hub stores it
// - Redirect downstream, peripheral and inter-processor interrupts
// - End of interrupt is broadcast downstream
// - Four phases per bus clock; line in two
package sbi_pkg;
  localparam int DATA_W      = 64;
  localparam int GROUPS      = 4;
  localparam int GROUP_W     = 16;
  localparam int GROUP_LIMIT = 8;
  localparam int MAX_ACTIVE  = 9;
  localparam int KIND_W      = 2;
  localparam logic [KIND_W-1:0] KIND_DATA = 2'h0;
  localparam logic [KIND_W-1:0] KIND_INTR = 2'h1;
  localparam logic [KIND_W-1:0] KIND_TPR  = 2'h2;
  localparam logic [KIND_W-1:0] KIND_EOI  = 2'h3;
  localparam int PHASE_CYC       = 4;
  localparam int PHASES_PER_BCLK = 4;
  localparam int BCLK_CYC        = PHASE_CYC * PHASES_PER_BCLK;
  localparam int LINE_BYTES      = 64;
  localparam int LINE_PHASES     = LINE_BYTES / (DATA_W / 8);
  localparam int ADDR_W          = 32;
  localparam int MSG_ADDR_LSB    = 32;
  localparam int WIN_LSB         = 20;
  localparam int WIN_W           = 12;
  localparam logic [WIN_W-1:0] WIN_BASE = 12'hfee;
  localparam int DEST_LSB        = 12;
  localparam int DEST_W          = 8;
  localparam int DM_LSB          = 8;
  localparam int DM_W            = 3;
  localparam logic [DM_W-1:0] DM_LOWEST = 3'h1;
  localparam int TPR_PRIO_LSB    = 0;
  localparam int TPR_THR_LSB     = 8;
  localparam int TPR_THR_W       = 8;
  localparam int EOI_VEC_LSB     = 0;
  localparam int EOI_VEC_W       = 8;

  typedef struct packed {
    logic [GROUPS-1:0] flag_n;
    logic [DATA_W-1:0] data_n;
  } sbi_phase_t;

  // Internal word to active-low wire form of one phase
  function automatic sbi_phase_t sbi_encode(input logic [DATA_W-1:0] d);
    sbi_phase_t p;
    int         cnt;
    p.data_n = ~d;
    p.flag_n = '1;
    for (int g = 0; g < GROUPS; g++) begin
      cnt = 0;
      for (int b = 0; b < GROUP_W; b++) begin
        cnt = cnt + int'(d[g*GROUP_W+b]);
      end
      if (cnt > GROUP_LIMIT) begin
        p.data_n[g*GROUP_W +: GROUP_W] = d[g*GROUP_W +: GROUP_W];
        p.flag_n[g] = 1'b0;
      end
    end
    return p;
  endfunction : sbi_encode

  // Wire form of one phase back to the internal word
  function automatic logic [DATA_W-1:0] sbi_decode(input sbi_phase_t p);
    logic [DATA_W-1:0] d;
    d = ~p.data_n;
    for (int g = 0; g < GROUPS; g++) begin
      if (!p.flag_n[g]) begin
        d[g*GROUP_W +: GROUP_W] = ~d[g*GROUP_W +: GROUP_W];
      end
    end
    return d;
  endfunction : sbi_decode
endpackage : sbi_pkg
